// ---- core/spu_consts.svh ----
/*
 * Register offsets, field positions and reset values of the serial port unit.
 * Assumes byte addressing on the register bus, one 32-bit word per register.
 */
`ifndef SPU_CONSTS_SVH
`define SPU_CONSTS_SVH

// Byte addresses of the registers.
`define SPU_OFF_CTRL      4'h0
`define SPU_OFF_CFG       4'h4
`define SPU_OFF_DATA      4'h8
`define SPU_OFF_CKR       4'hC

// Control register bit positions.
`define SPU_CT_DONE       7
`define SPU_CT_WCOL       6
`define SPU_CT_MODE_FAULT_FLAG       5
`define SPU_CT_OVR        4
`define SPU_CT_MODE_HI    3
`define SPU_CT_MODE_LO    2
`define SPU_CT_TXE        1
`define SPU_CT_EN         0

// Configuration register bit positions.
`define SPU_CF_BUSY       7
`define SPU_CF_MST        6
`define SPU_CF_NSS_IN     2
`define SPU_CF_SRMT       1
`define SPU_CF_RXBMT      0

// Reset values.
`define SPU_MODE_RESET    2'b01
`define SPU_CKR_RESET     8'h00

// Index of the last clock half period and of the last bit in one byte.
`define SPU_HALF_LAST     5'h0F
`define SPU_BIT_LAST      4'h7

`endif

// ---- core/spu_pkg.sv ----
/*
 * Types shared by the serial port unit modules.
 * Assumes the constants header is compiled alongside.
 */
package spu_pkg;
    // Engine state of the master side.
    typedef enum logic [0:0] {
        SPU_IDLE  = 1'b0,
        SPU_MXFER = 1'b1
    } spu_state_t;

    // Select pin configurations.
    typedef enum logic [1:0] {
        SPU_NSS_3W     = 2'b00,
        SPU_NSS_IN     = 2'b01,
        SPU_NSS_OUT_LO = 2'b10,
        SPU_NSS_OUT_HI = 2'b11
    } spu_nss_t;
endpackage

// ---- core/spu_sync.sv ----
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes each bit is an independent level; no word coherence is given.
 */
module spu_sync #(
    parameter int W = 4
) (
    input  wire logic         clk,   // System clock.
    input  wire logic         rst_n, // Synchronous reset, active low.
    input  wire logic [W-1:0] d,     // Asynchronous inputs.
    output logic      [W-1:0] q      // Synchronised outputs.
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } spu_sync_st_t;

    spu_sync_st_t r_q;
    spu_sync_st_t r_d;

    if (W < 1) begin : g_chk
        $error("spu_sync needs W of at least one");
    end

    // The first stage feeds only the second stage.
    always_comb begin
        r_d    = r_q;
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign q = r_q.s2;
endmodule // spu_sync

// ---- core/spu_tick_if.sv ----
/*
 * Link between the unit and its bit-rate tick generator.
 * Assumes both ends run on the same system clock.
 */
interface spu_tick_if;
    logic       run;   // Master transfer in progress.
    logic [7:0] div;   // Half period minus one, in clocks.
    logic       tick;  // One-cycle pulse per half period.

    modport gen (input run, input div, output tick);
    modport user (output run, output div, input tick);
endinterface

// ---- core/spu_tickgen.sv ----
/*
 * Half-period tick generator for the master serial clock.
 * Assumes run stays high for the whole master transfer.
 */
module spu_tickgen (
    input  wire logic clk,   // System clock.
    input  wire logic rst_n, // Synchronous reset, active low.
    spu_tick_if.gen   tk     // Rate and tick link.
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } spu_tg_st_t;

    spu_tg_st_t r_q;
    spu_tg_st_t r_d;

    // Counter restarts whenever run drops, so every transfer starts aligned.
    always_comb begin
        r_d      = r_q;
        r_d.tick = 1'b0;
        if (!tk.run) begin
            r_d.cnt = 8'h00;
        end else if (r_q.cnt == tk.div) begin
            r_d.cnt  = 8'h00;
            r_d.tick = 1'b1;
        end else begin
            r_d.cnt = r_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign tk.tick = r_q.tick;
endmodule // spu_tickgen

// ---- core/spu_top.sv ----
/*
 * Serial port unit: full-duplex, MSB-first byte engine with master and
 * slave roles, three select configurations and an Avalon-MM register slave.
 * Assumes all pin inputs are asynchronous to clk; pins are split into
 * input, output and active-low output enable, resolved outside.
 */
`include "spu_consts.svh"

// Operation
// - As master, master-out line carries shift register MSB, MSB first.
// - Slave-out line floats when disabled or unselected four-line slave.
// - Three-line slave always drives slave-out with shift register MSB.
// - Master makes serial clock; unselected four-line slave ignores it.
// - Select mode 00 is three-line; slave counts as always selected.
// - Mode 01 makes select an input; master falling edge disables master.
// - Mode 1x drives select pin as output at low mode bit level.
// - Select maps to a pin in every mode except three-line.
// - Master-enable bit 6 of configuration register enters master mode.
// - Data write loads transmit buffer; empty shifter takes it and starts.
// - A started master transfer shifts out at once with serial clock.
// - Completion flag bit 7 set at each transfer end; request raised.
// - Master captures slave-out during every transfer; one flag for both.
// - Received bits enter MSB first; full byte copied to receive buffer.
// - Multi-master is the default mode 01; select disables this master.
// - Select falling clears master and unit enable, sets mode fault.
// - Mode 00 master is three-line single master, no select pin.
// - Mode 1x master is four-line single master, software sets select.
module spu_top
    import spu_pkg::*;
(
    input  wire logic        clk,                // System clock.
    input  wire logic        rst_n,              // Sync reset, active low.
    input  wire logic [3:0]  avs_address,        // Byte address.
    input  wire logic        avs_read,           // Read request.
    input  wire logic        avs_write,          // Write request.
    input  wire logic [3:0]  avs_byteenable,     // Byte lanes.
    input  wire logic [31:0] avs_writedata,      // Write data.
    output logic      [31:0] avs_readdata,       // Read data.
    output logic             avs_waitrequest,    // Stall, high when idle.
    input  wire logic        sck_i,              // Serial clock pin in.
    output logic             sck_o,              // Serial clock pin out.
    output logic             sck_oe_n,           // Clock drive, active low.
    input  wire logic        mosi_i,             // Master-out pin in.
    output logic             mosi_o,             // Master-out pin out.
    output logic             mosi_oe_n,          // Master-out drive enable.
    input  wire logic        miso_i,             // Slave-out pin in.
    output logic             miso_o,             // Slave-out pin out.
    output logic             miso_oe_n,          // Slave-out drive enable.
    input  wire logic        nss_i,              // Select pin in.
    output logic             nss_o,              // Select pin out.
    output logic             nss_oe_n,           // Select drive enable.
    output logic             nss_pin_map,        // Select routed to a pin.
    output logic             irq_req             // Any flag set, level.
);
    import spu_pkg::*;

    typedef struct packed {
        spu_state_t  st;
        logic        ack;
        logic        waitreq;
        logic [31:0] rdata;
        logic        en;
        logic        mst;
        logic        done;
        logic        wcol;
        logic        mode_fault_flag;
        logic        ovr;
        logic [1:0]  nss_mode;
        logic [7:0]  ckr;
        logic [7:0]  txbuf;
        logic [7:0]  shift;
        logic [7:0]  rxbuf;
        logic        tx_full;
        logic        sh_full;
        logic        rx_full;
        logic [4:0]  half_cnt;
        logic [3:0]  bit_cnt;
        logic        samp;
        logic        sck;
        logic        sck_prev;
        logic        nss_prev;
        logic        sck_o;
        logic        sck_oe_n;
        logic        mosi_o;
        logic        mosi_oe_n;
        logic        miso_o;
        logic        miso_oe_n;
        logic        nss_o;
        logic        nss_oe_n;
        logic        nss_map;
        logic        irq;
    } spu_top_st_t;

    spu_top_st_t r_q;
    spu_top_st_t r_d;
    logic [3:0]  pin_s;
    logic        sck_s;
    logic        mosi_s;
    logic        miso_s;
    logic        nss_s;
    logic        master_on;
    logic        slave_on;
    logic        selected;
    logic        sck_rise;
    logic        sck_fall;
    logic        nss_fall;
    logic [7:0]  wbyte;
    logic        wr_ok;

    spu_tick_if tk ();

    // Every pin input passes two flops before the engine looks at it.
    spu_sync #(.W(4)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({sck_i, mosi_i, miso_i, nss_i}),
        .q     (pin_s)
    );

    spu_tickgen u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .tk    (tk)
    );

    assign {sck_s, mosi_s, miso_s, nss_s} = pin_s;
    assign tk.run = (r_q.st == SPU_MXFER);
    assign tk.div = r_q.ckr;

    // Role decode and edge detection on the synchronised pins.
    assign master_on = r_q.en && r_q.mst;
    assign slave_on  = r_q.en && !r_q.mst;
    assign selected  = (r_q.nss_mode == SPU_NSS_3W) ||
                       ((r_q.nss_mode == SPU_NSS_IN) && !nss_s);
    assign sck_rise  = sck_s && !r_q.sck_prev;
    assign sck_fall  = !sck_s && r_q.sck_prev;
    assign nss_fall  = !nss_s && r_q.nss_prev;
    assign wbyte     = avs_writedata[7:0];
    assign wr_ok     = avs_write && avs_byteenable[0];

    // Bus first, then the serial engine, so hardware flag sets win.
    always_comb begin
        r_d          = r_q;
        r_d.sck_prev = sck_s;
        r_d.nss_prev = nss_s;

        // Answer one cycle after the request; act while waitrequest is low.
        if (r_q.ack) begin
            r_d.ack = 1'b0;
            if (wr_ok) begin
                case (avs_address)
                    `SPU_OFF_CTRL: begin
                        // Flags clear on a written zero only.
                        r_d.done     = r_q.done && wbyte[`SPU_CT_DONE];
                        r_d.wcol     = r_q.wcol && wbyte[`SPU_CT_WCOL];
                        r_d.mode_fault_flag     = r_q.mode_fault_flag && wbyte[`SPU_CT_MODE_FAULT_FLAG];
                        r_d.ovr      = r_q.ovr && wbyte[`SPU_CT_OVR];
                        r_d.nss_mode = wbyte[`SPU_CT_MODE_HI:`SPU_CT_MODE_LO];
                        r_d.en       = wbyte[`SPU_CT_EN];
                    end
                    `SPU_OFF_CFG: begin
                        r_d.mst = wbyte[`SPU_CF_MST];
                    end
                    `SPU_OFF_DATA: begin
                        if (r_q.tx_full) begin
                            r_d.wcol = 1'b1;
                        end else begin
                            r_d.txbuf   = wbyte;
                            r_d.tx_full = 1'b1;
                        end
                    end
                    `SPU_OFF_CKR: begin
                        r_d.ckr = wbyte;
                    end
                    default: begin
                    end
                endcase
            end
            if (avs_read && (avs_address == `SPU_OFF_DATA)) begin
                r_d.rx_full = 1'b0;
            end
        end else if (avs_read || avs_write) begin
            r_d.ack   = 1'b1;
            r_d.rdata = 32'h0000_0000;
            case (avs_address)
                `SPU_OFF_CTRL: begin
                    r_d.rdata[7:0] = {r_q.done, r_q.wcol, r_q.mode_fault_flag, r_q.ovr,
                                      r_q.nss_mode, !r_q.tx_full, r_q.en};
                end
                `SPU_OFF_CFG: begin
                    r_d.rdata[`SPU_CF_BUSY]   = (r_q.st == SPU_MXFER) ||
                                                (r_q.bit_cnt != 4'h0);
                    r_d.rdata[`SPU_CF_MST]    = r_q.mst;
                    r_d.rdata[`SPU_CF_NSS_IN] = nss_s;
                    r_d.rdata[`SPU_CF_SRMT]   = !r_q.sh_full;
                    r_d.rdata[`SPU_CF_RXBMT]  = !r_q.rx_full;
                end
                `SPU_OFF_DATA: begin
                    r_d.rdata[7:0] = r_q.rxbuf;
                end
                `SPU_OFF_CKR: begin
                    r_d.rdata[7:0] = r_q.ckr;
                end
                default: begin
                end
            endcase
        end

        // Master engine: even ticks raise the clock and sample, odd ticks
        // lower it and shift the sampled bit in.
        case (r_q.st)
            SPU_MXFER: begin
                if (tk.tick) begin
                    if (!r_q.half_cnt[0]) begin
                        r_d.sck  = 1'b1;
                        r_d.samp = miso_s;
                    end else begin
                        r_d.sck   = 1'b0;
                        r_d.shift = {r_q.shift[6:0], r_q.samp};
                    end
                    r_d.half_cnt = r_q.half_cnt + 5'h01;
                    if (r_q.half_cnt == `SPU_HALF_LAST) begin
                        r_d.st      = SPU_IDLE;
                        r_d.sh_full = 1'b0;
                        r_d.done    = 1'b1;
                        r_d.rxbuf   = {r_q.shift[6:0], r_q.samp};
                        r_d.rx_full = 1'b1;
                    end
                end
            end
            default: begin
                r_d.sck = 1'b0;
            end
        endcase

        // Slave engine: an unselected slave sees no clock edges.
        if (slave_on && (r_q.nss_mode == SPU_NSS_IN) && nss_fall) begin
            r_d.bit_cnt = 4'h0;
        end else if (slave_on && selected && sck_rise) begin
            r_d.samp    = mosi_s;
            r_d.bit_cnt = r_q.bit_cnt + 4'h1;
            if (r_q.bit_cnt == `SPU_BIT_LAST) begin
                r_d.bit_cnt = 4'h0;
                r_d.shift   = {r_q.shift[6:0], mosi_s};
                r_d.sh_full = 1'b0;
                r_d.done    = 1'b1;
                if (r_q.rx_full) begin
                    r_d.ovr = 1'b1;
                end else begin
                    r_d.rxbuf   = {r_q.shift[6:0], mosi_s};
                    r_d.rx_full = 1'b1;
                end
            end
        end else if (slave_on && selected && sck_fall &&
                     (r_q.bit_cnt != 4'h0)) begin
            r_d.shift = {r_q.shift[6:0], r_q.samp};
        end

        // Losing the bus in multi-master mode drops both enables.
        if (master_on && (r_q.nss_mode == SPU_NSS_IN) && nss_fall) begin
            r_d.en   = 1'b0;
            r_d.mst  = 1'b0;
            r_d.mode_fault_flag = 1'b1;
        end

        // A disabled unit stops mid-byte; the bit count restarts with it.
        if (!r_d.en || !r_d.mst) begin
            if (r_q.st == SPU_MXFER) begin
                r_d.sh_full = 1'b0;
            end
            r_d.st       = SPU_IDLE;
            r_d.sck      = 1'b0;
            r_d.half_cnt = 5'h00;
        end
        if (!r_d.en) begin
            r_d.bit_cnt = 4'h0;
        end

        // An empty shifter takes the buffered byte at once.
        if (r_d.tx_full && !r_d.sh_full) begin
            r_d.shift   = r_d.txbuf;
            r_d.tx_full = 1'b0;
            r_d.sh_full = 1'b1;
            if (r_d.en && r_d.mst) begin
                r_d.st       = SPU_MXFER;
                r_d.half_cnt = 5'h00;
                r_d.sck      = 1'b0;
            end
        end

        // Pin drive follows the settled role; enables are active low.
        r_d.mosi_o    = r_d.shift[7];
        r_d.mosi_oe_n = !(r_d.en && r_d.mst);
        r_d.miso_o    = r_d.shift[7];
        r_d.miso_oe_n = !(r_d.en && !r_d.mst &&
                          ((r_d.nss_mode == SPU_NSS_3W) ||
                           ((r_d.nss_mode == SPU_NSS_IN) && !nss_s)));
        r_d.sck_o     = r_d.sck;
        r_d.sck_oe_n  = !(r_d.en && r_d.mst);
        r_d.nss_o     = r_d.nss_mode[0];
        r_d.nss_oe_n  = !r_d.nss_mode[1];
        r_d.nss_map   = (r_d.nss_mode != SPU_NSS_3W);
        r_d.irq       = r_d.done || r_d.wcol || r_d.mode_fault_flag || r_d.ovr;
        r_d.waitreq   = !r_d.ack;
    end

    // Reset leaves the unit disabled, in multi-master select mode.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_q           <= '0;
            r_q.st        <= SPU_IDLE;
            r_q.waitreq   <= 1'b1;
            r_q.nss_mode  <= `SPU_MODE_RESET;
            r_q.ckr       <= `SPU_CKR_RESET;
            r_q.sck_oe_n  <= 1'b1;
            r_q.mosi_oe_n <= 1'b1;
            r_q.miso_oe_n <= 1'b1;
            r_q.nss_oe_n  <= 1'b1;
            r_q.nss_o     <= 1'b1;
            r_q.nss_map   <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign avs_readdata    = r_q.rdata;
    assign avs_waitrequest = r_q.waitreq;
    assign sck_o           = r_q.sck_o;
    assign sck_oe_n        = r_q.sck_oe_n;
    assign mosi_o          = r_q.mosi_o;
    assign mosi_oe_n       = r_q.mosi_oe_n;
    assign miso_o          = r_q.miso_o;
    assign miso_oe_n       = r_q.miso_oe_n;
    assign nss_o           = r_q.nss_o;
    assign nss_oe_n        = r_q.nss_oe_n;
    assign nss_pin_map     = r_q.nss_map;
    assign irq_req         = r_q.irq;
endmodule // spu_top

// ---- dv/spu_far_model.sv ----
/* Behavioural far side: a mode 0 slave and a competing master's select.
   Assumes the clock line idles low and only moves during frames. */
module spu_far_model #(
    parameter logic [7:0] REPLY = 8'hA5
) (
    input  wire logic       sck,  // Serial clock from the master.
    input  wire logic       mosi, // Data from the master.
    input  wire logic       grab, // Competing master takes the bus.
    output logic            miso, // Data to the master.
    output logic            nss,  // Select line, pulled up.
    output logic      [7:0] got   // Last whole byte received.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tx_q = REPLY;
    logic [7:0] rx_q = 8'h00;
    int         cnt = 0;

    // The reply leaves MSB first; the master samples it on the rise.
    assign miso = tx_q[7];
    // Only a competing master lowers the pulled-up select line.
    assign nss = grab ? 1'b0 : 1'b1;
    // Capture on the rising edge.
    always @(posedge sck) begin
        rx_q <= {rx_q[6:0], mosi};
        cnt  <= (cnt == 8) ? 1 : cnt + 1;
    end
    // Shift on the fall; a start-up glitch before any rise is ignored.
    always @(negedge sck) begin
        if (cnt == 8) begin
            got  <= rx_q;
            tx_q <= REPLY;
        end else if (cnt != 0) begin
            tx_q <= {tx_q[6:0], ~tx_q[7]};
        end
    end
endmodule // spu_far_model

// ---- dv/spu_master_select_modes_tb.sv ----
/* Self-checking bench of the serial port unit over its register bus.
   Assumes the far-side model and the bound checker are compiled first. */
module spu_master_select_modes_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] REPLY = 8'hA5;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, sck_o, sck_oe_n, mosi_o, mosi_oe_n;
    logic        miso_o, miso_oe_n, nss_o, nss_oe_n, nss_pin_map, irq_req;
    logic        far_miso, far_nss;
    logic        grab = 1'b0;
    wire logic   sck_w, mosi_w, miso_w, nss_w;
    logic [7:0]  far_got;
    int          num_errors = 0;
    int          comparisons = 0;
    int          cycles = 0;

    always #5 clk = ~clk;
    // Lines resolve from their drivers; clock and master-out pull down.
    assign sck_w  = (sck_oe_n === 1'b0) ? sck_o : 1'b0;
    assign mosi_w = (mosi_oe_n === 1'b0) ? mosi_o : 1'b0;
    assign miso_w = (miso_oe_n === 1'b0) ? miso_o : far_miso;
    assign nss_w  = (nss_oe_n === 1'b0) ? nss_o : far_nss;

    spu_top dut_u (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sck_i(sck_w), .sck_o(sck_o),
        .sck_oe_n(sck_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o),
        .mosi_oe_n(mosi_oe_n), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe_n(miso_oe_n), .nss_i(nss_w), .nss_o(nss_o),
        .nss_oe_n(nss_oe_n), .nss_pin_map(nss_pin_map), .irq_req(irq_req)
    );
    spu_far_model #(.REPLY(REPLY)) far_u (
        .sck(sck_w), .mosi(mosi_w), .grab(grab), .miso(far_miso),
        .nss(far_nss), .got(far_got)
    );

    task automatic print_verdict;
        if (num_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t pin=%h exp=%h", $time, got, exp);
        end
    endtask
    // The request holds until waitrequest is seen low at an edge.
    task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata[7:0];
        avs_read <= 1'b0;
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_write     <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    // Polling is bounded so a stuck flag shows as one mismatch.
    task automatic wait_bit(input logic [3:0] a, input int b, input logic v);
        logic [7:0] d;
        int         n;
        n = 0;
        do begin
            bus_rd(a, d);
            n++;
        end while (d[b] !== v && n < 200);
        chk_pin(d[b], v);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic t_reset_vals;
        logic [7:0] d;
        bus_rd(4'h0, d);
        chk_byte(d, 8'h06); // Multi-master default.
        bus_rd(4'h4, d);
        chk_byte(d, 8'h07);
        bus_rd(4'h2, d);
        chk_byte(d, 8'h00);
        chk_pin(nss_pin_map, 1'b1); // Mapped in mode 01.
        chk_pin(miso_oe_n, 1'b1); // Disabled floats.
    endtask
    // Two bytes back to back in three-line master mode.
    task automatic t_master;
        logic [7:0] d;
        bus_wr(4'hC, 8'h03);
        bus_wr(4'h0, 8'h01);
        bus_wr(4'h4, 8'h40); // Master enable.
        bus_wr(4'h8, 8'h3C); // Starts at once.
        bus_wr(4'h8, 8'hC3); // Waits in buffer.
        wait_bit(4'h0, 7, 1'b1); // Done flag.
        chk_byte(far_got, 8'h3C); // Sent MSB first.
        chk_pin(irq_req, 1'b1); // Request.
        chk_pin(nss_pin_map, 1'b0); // No select pin.
        bus_rd(4'h8, d);
        chk_byte(d, REPLY); // Captured byte.
        bus_wr(4'h0, 8'h01); // Software clears done.
        wait_bit(4'h0, 7, 1'b1); // Second byte follows.
        chk_byte(far_got, 8'hC3); // Shifted out.
        bus_rd(4'h8, d);
        chk_byte(d, REPLY); // Receive buffer.
    endtask
    task automatic t_sel_out;
        bus_wr(4'h0, 8'h09); // Output select as master.
        idle(3);
        chk_pin(nss_oe_n, 1'b0); // Driven.
        chk_pin(nss_o, 1'b0); // Low bit level.
        bus_wr(4'h0, 8'h0D);
        idle(3);
        chk_pin(nss_o, 1'b1); // Low bit level.
    endtask
    task automatic t_fault;
        logic [7:0] d;
        bus_wr(4'h0, 8'h05);
        bus_wr(4'h4, 8'h40);
        grab <= 1'b1;
        wait_bit(4'h0, 5, 1'b1); // Fault raised.
        bus_rd(4'h0, d);
        chk_byte(d, 8'h26); // Unit disabled.
        bus_rd(4'h4, d);
        chk_byte(d, 8'h03); // Master cleared.
        chk_pin(irq_req, 1'b1); // Request.
        bus_wr(4'h0, 8'h24);
        bus_rd(4'h0, d);
        chk_byte(d, 8'h26); // Writing one keeps it.
        bus_wr(4'h0, 8'h04);
        bus_rd(4'h0, d);
        chk_byte(d, 8'h06); // Writing zero clears.
        chk_pin(irq_req, 1'b0);
        grab <= 1'b0;
    endtask
    task automatic t_slave;
        bus_wr(4'h0, 8'h01);
        bus_wr(4'h8, 8'h80);
        idle(3);
        chk_pin(miso_oe_n, 1'b0); // Always selected.
        chk_pin(miso_o, 1'b1); // Shifter MSB.
        bus_wr(4'h0, 8'h05);
        idle(3);
        chk_pin(miso_oe_n, 1'b1); // Unselected floats.
        grab <= 1'b1;
        idle(6);
        chk_pin(miso_oe_n, 1'b0); // Select input.
        bus_wr(4'h0, 8'h04);
        idle(3);
        chk_pin(miso_oe_n, 1'b1); // Disabled floats.
    endtask

    // The whole run takes a few hundred cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict;
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_vals;
        t_master;
        t_sel_out;
        t_fault;
        t_slave;
        print_verdict;
    end
endmodule // spu_master_select_modes_tb

// ---- dv/spu_properties.sv ----
/* Concurrent checks on the serial port unit's pins and bus handshake.
   Assumes it is bound to spu_top and sees only that module's ports. */
module spu_checker (
    input wire logic clk,             // System clock.
    input wire logic rst_n,           // Sync reset, active low.
    input wire logic avs_read,        // Read request.
    input wire logic avs_write,       // Write request.
    input wire logic avs_waitrequest, // Bus stall.
    input wire logic sck_o,           // Serial clock out.
    input wire logic sck_oe_n,        // Clock drive, active low.
    input wire logic mosi_o,          // Master-out data.
    input wire logic mosi_oe_n,       // Master-out drive, active low.
    input wire logic miso_oe_n,       // Slave-out drive, active low.
    input wire logic nss_i,           // Select pin in.
    input wire logic nss_oe_n,        // Select drive, active low.
    input wire logic nss_pin_map,     // Select routed to a pin.
    input wire logic irq_req          // Flag request.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // A multi-master master sees a competitor pull the select low.
    sequence s_sel_fall;
        !sck_oe_n && nss_pin_map && nss_oe_n && $fell(nss_i);
    endsequence
    // The master lets go of its lines soon after, not eventually.
    sequence s_bus_drop;
        ##[1:8] sck_oe_n;
    endsequence

    a_wait_single: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest stayed high after a request");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_master_pair: assert property (mosi_oe_n == sck_oe_n) // Pair.
        else $error("clock and master-out drives disagree");
    a_miso_slave: assert property (!miso_oe_n |-> sck_oe_n) // Slave.
        else $error("slave-out driven while master");
    a_sel_mapped: assert property (!nss_oe_n |-> nss_pin_map) // Pin.
        else $error("select driven but not mapped");
    a_mosi_low: assert property ( // Shift edge.
        !mosi_oe_n && $past(!mosi_oe_n) && $changed(mosi_o) |-> !sck_o)
        else $error("master-out changed while clock high");
    a_fault_drop: assert property (s_sel_fall |-> s_bus_drop) // Lose.
        else $error("master kept the bus after select fell");
    a_fault_irq: assert property ( // Fault raises request.
        s_sel_fall |-> ##[1:8] irq_req)
        else $error("no request after mode fault");
    a_irq_clear: assert property ( // Flags clear by write.
        $fell(irq_req) |-> $past(avs_write, 1) || $past(avs_write, 2))
        else $error("request fell without a write");
endmodule // spu_checker

bind spu_top spu_checker chk_u (
    .clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .sck_o(sck_o), .sck_oe_n(sck_oe_n),
    .mosi_o(mosi_o), .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n),
    .nss_i(nss_i), .nss_oe_n(nss_oe_n), .nss_pin_map(nss_pin_map),
    .irq_req(irq_req)
);
